// File: msc_top.sv
// Purpose: module-side sideband control: select, reset, low power,
//          presence, interrupt and a small two-wire map
// Assumes: i_rst_n low models power-up; pins are asynchronous
// Notes: open-drain pins split into output and output enable
`timescale 1ns/1ns
module msc_top #(
  parameter int P_INIT_CYCLES = msc_pkg::INIT_CYCLES,
  parameter int P_RESET_MIN_CYCLES = msc_pkg::RESET_MIN_CYCLES,
  parameter logic [6:0] P_DEV_ADDR = msc_pkg::DEV_ADDR
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_module_select_n,
  input wire logic i_module_reset_n,
  input wire logic i_low_power_select,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_interrupt_n_o,
  output logic o_interrupt_n_oe,
  output logic o_module_present_n,
  output logic o_data_not_ready,
  output logic o_high_power_en
);
  import msc_pkg::*;

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  msc_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_module_select_n, i_module_reset_n, i_low_power_select,
              i_scl, i_sda}),
    .i_init(5'h1b),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  wire sel_n = pin_lvl[4];
  wire mrst_n = pin_lvl[3];
  wire lp_sel = pin_lvl[2];
  wire scl = pin_lvl[1];
  wire sda = pin_lvl[0];
  wire scl_rise = pin_rise[1];
  wire scl_fall = pin_fall[1];
  wire bus_start = scl & pin_fall[0];
  wire bus_stop = scl & pin_rise[0];

  // ****************************************************
  // reset qualification and initialisation
  // ****************************************************
  logic [RESET_CNT_W-1:0] rcnt_q;
  logic mreset_q;
  logic [INIT_CNT_W-1:0] icnt_q;
  logic dnr_q;
  logic intr_q;
  logic stat_rd;
  logic ctrl_we;
  logic [7:0] ctrl_q;
  logic [7:0] wdata;

  wire rst_long = (rcnt_q >= RESET_CNT_W'(P_RESET_MIN_CYCLES - 1));
  wire init_done = dnr_q & ~mreset_q &
                   (icnt_q == INIT_CNT_W'(P_INIT_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mrst_n) begin
      rcnt_q <= '0;
    end else if (!rst_long) begin
      rcnt_q <= rcnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mreset_q <= 1'b0;
    end else begin
      mreset_q <= ~mrst_n & rst_long;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mreset_q || !dnr_q) begin
      icnt_q <= '0;
    end else begin
      icnt_q <= icnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mreset_q) begin
      dnr_q <= 1'b1;
    end else if (init_done) begin
      dnr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mreset_q) begin
      intr_q <= 1'b0;
    end else if (init_done) begin
      intr_q <= 1'b1;
    end else if (stat_rd) begin
      intr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || mreset_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_q <= wdata;
    end
  end

  // ****************************************************
  // two-wire slave
  // ****************************************************
  msc_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic oe_q, oe_d;
  logic out_q, out_d;
  logic rw_q, rw_d;
  logic first_q, first_d;

  wire [7:0] status_byte = 8'(({7'h00, intr_q} << STAT_INT_BIT) |
                              ({7'h00, dnr_q} << STAT_NOT_READY_BIT));
  wire [7:0] map_rd = (ptr_q == MAP_STATUS) ? status_byte :
                      (ptr_q == MAP_CONTROL) ? ctrl_q :
                      (ptr_q == MAP_IDENT) ? IDENT_VALUE : 8'h00;
  wire byte_done = (cnt_q == BITS_PER_BYTE);
  wire addr_hit = (sh_q[7:1] == P_DEV_ADDR);
  wire bus_ok = ~sel_n & ~mreset_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    out_d = out_q;
    rw_d = rw_q;
    first_d = first_q;
    stat_rd = 1'b0;
    ctrl_we = 1'b0;
    wdata = sh_q;
    if (!bus_ok || bus_stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && byte_done) begin
            out_d = 1'b0;
            if (st_q == ST_ADDR) begin
              oe_d = addr_hit;
              rw_d = sh_q[0];
              st_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            end else begin
              oe_d = 1'b1;
              st_d = ST_WR_ACK;
              first_d = 1'b0;
              if (first_q) begin
                ptr_d = sh_q;
              end else begin
                ctrl_we = (ptr_q == MAP_CONTROL);
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (scl_rise && st_q == ST_RD_ACK && sda) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            if (rw_q) begin
              sh_d = {map_rd[6:0], 1'b0};
              out_d = map_rd[7];
              oe_d = 1'b1;
              cnt_d = 4'h1;
              stat_rd = (ptr_q == MAP_STATUS);
              st_d = ST_RD_BYTE;
            end else begin
              oe_d = 1'b0;
              cnt_d = 4'h0;
              first_d = 1'b1;
              st_d = ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            st_d = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (byte_done) begin
              oe_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d = ST_RD_ACK;
            end else begin
              out_d = sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
      out_q <= 1'b1;
      rw_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
      out_q <= out_d;
      rw_q <= rw_d;
      first_q <= first_d;
    end
  end

  // ****************************************************
  // power limit and pins
  // ****************************************************
  logic hp_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hp_q <= 1'b0;
    end else begin
      hp_q <= ~lp_sel & ~ctrl_q[CTRL_FORCE_LP_BIT] & ~dnr_q;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe_q & ~out_q;
  assign o_interrupt_n_o = 1'b0;
  assign o_interrupt_n_oe = intr_q;
  assign o_module_present_n = 1'b0;
  assign o_data_not_ready = dnr_q;
  assign o_high_power_en = hp_q;
endmodule

// File: msc_pkg.sv
// Purpose: constants and pin synchroniser for module sideband control
// Assumes: single 20 MHz clock, synchronous active-low reset
// Notes: the synchroniser also yields one-cycle edge pulses
//
// Notes on behaviour
// - serial bus answered only while selected
// - long reset pulse restores all defaults except the map pointer
// - completion: interrupt with not-ready flag clear
// - power-up posts completion interrupt unprompted
// - low-power input limits module power
// - module grounds presence line when inserted
// - open-collector interrupt pulled low on events
// - fully functional within 2000 ms
`timescale 1ns/1ns
package msc_pkg;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int INIT_TIME_MS = 2000;
  localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
  localparam int INIT_CNT_W = 26;
  localparam int RESET_MIN_CYCLES = 16;
  localparam int RESET_CNT_W = 16;
  // ****************************************************
  // serial bus and memory map
  // ****************************************************
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] MAP_STATUS = 8'h00;
  localparam logic [7:0] MAP_CONTROL = 8'h01;
  localparam logic [7:0] MAP_IDENT = 8'h02;
  localparam int STAT_NOT_READY_BIT = 0;
  localparam int STAT_INT_BIT = 1;
  localparam int CTRL_FORCE_LP_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // arbitrary identity value
  localparam logic [7:0] IDENT_VALUE = 8'h5a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
    ST_RD_BYTE, ST_RD_ACK
  } msc_state_t;
endpackage

module msc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  input wire logic [W-1:0] i_init,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= i_init;
      sync_q <= i_init;
      prev_q <= i_init;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule

// File: msc_monitor.sv
// Purpose: checker on the pins of msc_top
// Assumes: bench uses P_RESET_MIN_CYCLES of 4
// Notes: attached by the bind below
`timescale 1ns/1ns
module msc_monitor #(
  parameter int P_INIT_CYCLES = 50
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_module_select_n,
  input wire logic i_module_reset_n,
  input wire logic i_low_power_select,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_interrupt_n_o,
  input wire logic o_interrupt_n_oe,
  input wire logic o_module_present_n,
  input wire logic o_data_not_ready,
  input wire logic o_high_power_en
);
  localparam int INIT_MAX = P_INIT_CYCLES + 30;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // steps
  // ****
  sequence short_pulse_s;
    !o_data_not_ready && i_module_reset_n ##1 !i_module_reset_n
      ##1 i_module_reset_n;
  endsequence
  sequence long_reset_s;
    !i_module_reset_n [*8];
  endsequence
  present_gnd_a: assert property (!o_module_present_n)
    else $error("presence not low");
  open_drain_a: assert property (!o_interrupt_n_o && !o_sda_o)
    else $error("open drain level not low");
  desel_quiet_a: assert property (
    i_module_select_n [*5] |-> !o_sda_oe) else $error("sda driven");
  low_power_a: assert property (
    i_low_power_select [*5] |-> !o_high_power_en) else $error("high power");
  busy_power_a: assert property (
    o_data_not_ready [*2] |-> !o_high_power_en) else $error("power in init");
  done_int_a: assert property (
    $fell(o_data_not_ready) |-> o_interrupt_n_oe) else $error("no done int");
  long_reset_a: assert property (
    long_reset_s |-> ##2 o_data_not_ready && !o_interrupt_n_oe)
    else $error("reset not taken");
  short_pulse_a: assert property (
    short_pulse_s |=> !o_data_not_ready [*6]) else $error("short reset");
  power_up_a: assert property (
    $rose(i_rst_n) |-> ##[1:INIT_MAX] o_interrupt_n_oe)
    else $error("no power-up int");
endmodule

bind msc_top msc_monitor #(.P_INIT_CYCLES(P_INIT_CYCLES)) i_msc_monitor (
  .i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_module_select_n(i_module_select_n),
  .i_module_reset_n(i_module_reset_n),
  .i_low_power_select(i_low_power_select),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .o_interrupt_n_o(o_interrupt_n_o), .o_interrupt_n_oe(o_interrupt_n_oe),
  .o_module_present_n(o_module_present_n),
  .o_data_not_ready(o_data_not_ready), .o_high_power_en(o_high_power_en)
);

// File: msc_host.sv
// Purpose: host controller model on the two-wire bus
// Assumes: tasks entered 2 ns after a clock edge
// Notes: scl idles high; released sda is pulled up
`timescale 1ns/1ns
module msc_host (
  input wire logic i_sda,
  input wire logic i_slow,
  output logic o_scl,
  output logic o_sda_oe
);
  initial begin
    o_scl = 1'h1;
    o_sda_oe = 1'h0;
  end
  task automatic start();
    o_sda_oe = 1'h0;
    #200 o_sda_oe = 1'h1;
    #200 o_scl = 1'h0;
  endtask
  task automatic stop();
    #100 o_sda_oe = 1'h1;
    #100 o_scl = 1'h1;
    #200 o_sda_oe = 1'h0;
    #200;
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic last,
                       output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, last};
    for (int i = 8; i >= 0; i--) begin
      #100 o_sda_oe = !sh[i];
      #(i_slow ? 500 : 100) o_scl = 1'h1;
      #190 sh[i] = i_sda;
      #10 o_scl = 1'h0;
    end
    rx = sh[8:1];
    ack = sh[0];
  endtask
endmodule

// File: module_sideband_control_tb_top.sv
// Purpose: self-checking bench for msc_top
// Assumes: short init and reset counts
// Notes: rows cover map reads; resets follow by hand
`timescale 1ns/1ns
module module_sideband_control_tb_top;
  import msc_pkg::*;
  typedef struct {logic s; logic l; logic [7:0] p, d; logic a, h;} msc_row_t;
  logic clk = 1'h0, rst_n = 1'h0, sel_n = 1'h0, mrst_n = 1'h1;
  logic lp = 1'h0, slow = 1'h0, ak;
  logic sda_o, sda_oe, int_o, int_oe, pres_n, nr, hp, scl, h_oe;
  logic [7:0] rx;
  int bad_count = 0;
  int cmp_count = 0;
  wire sda = !(h_oe | sda_oe);
  wire int_n = !int_oe;
  msc_row_t rows [5] = '{
    '{1'h0, 1'h0, 8'h00, 8'h02, 1'h0, 1'h1},
    '{1'h0, 1'h0, 8'h00, 8'h00, 1'h0, 1'h1},
    '{1'h0, 1'h1, 8'h02, IDENT_VALUE, 1'h0, 1'h0},
    '{1'h0, 1'h0, 8'h07, 8'h00, 1'h0, 1'h1},
    '{1'h1, 1'h0, 8'h02, 8'hff, 1'h1, 1'h1}};
  always #25 clk = ~clk;
  msc_top #(.P_INIT_CYCLES(50), .P_RESET_MIN_CYCLES(4)) i_msc_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_module_select_n(sel_n),
    .i_module_reset_n(mrst_n), .i_low_power_select(lp), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .o_interrupt_n_o(int_o), .o_interrupt_n_oe(int_oe),
    .o_module_present_n(pres_n), .o_data_not_ready(nr),
    .o_high_power_en(hp));
  msc_host i_msc_host (.i_sda(sda), .i_slow(slow), .o_scl(scl),
    .o_sda_oe(h_oe));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_int();
    for (int n = 0; n < 400 && int_n; n++) tick(1);
    chk(8'(int_n), 8'h00);
    if (int_n) begin
      give_verdict();
    end else begin
      tick(2);
    end
  endtask
  task automatic acc(input logic [7:0] p, input logic w,
                     input logic [7:0] v);
    logic [7:0] d;
    logic a2;
    i_msc_host.start();
    i_msc_host.xbyte({DEV_ADDR, 1'h0}, 1'h1, d, ak);
    i_msc_host.xbyte(p, 1'h1, d, a2);
    if (w) i_msc_host.xbyte(v, 1'h1, d, a2);
    i_msc_host.stop();
    if (!w) begin
      i_msc_host.start();
      i_msc_host.xbyte({DEV_ADDR, 1'h1}, 1'h1, d, a2);
      i_msc_host.xbyte(8'hff, 1'h1, rx, a2);
      i_msc_host.stop();
    end
  endtask
  initial begin
    tick(20);
    rst_n = 1'h1;
    wait_int();
    chk(8'(nr), 8'h00);
    chk(8'(pres_n), 8'h00);
    foreach (rows[k]) begin
      sel_n = rows[k].s;
      lp = rows[k].l;
      tick(6);
      acc(rows[k].p, 1'h0, 8'h00);
      chk(8'(ak), 8'(rows[k].a));
      chk(rx, rows[k].d);
      chk(8'(hp), 8'(rows[k].h));
    end
    chk(8'(int_n), 8'h01);
    sel_n = 1'h0;
    slow = 1'h1;
    tick(6);
    acc(MAP_CONTROL, 1'h1, 8'h01);
    slow = 1'h0;
    tick(4);
    chk(8'(hp), 8'h00);
    mrst_n = 1'h0;
    tick(1);
    mrst_n = 1'h1;
    tick(10);
    chk(8'(nr), 8'h00);
    mrst_n = 1'h0;
    tick(20);
    chk(8'(nr), 8'h01);
    mrst_n = 1'h1;
    wait_int();
    chk(8'(hp), 8'h01);
    acc(MAP_CONTROL, 1'h0, 8'h00);
    chk(rx, CTRL_RESET);
    give_verdict();
  end
endmodule
